//--- rtl/tpmc_defs.svh
`ifndef TPMC_DEFS_SVH
`define TPMC_DEFS_SVH
// register byte offsets
`define TPMC_OFF_CMD 12'h000
`define TPMC_OFF_RESP 12'h004
`define TPMC_OFF_STAT 12'h008
`define TPMC_OFF_MASK 12'h00C
`define TPMC_OFF_FMODE 12'h010
`define TPMC_OFF_CLRMODE 12'h014
`define TPMC_OFF_PLUGON 12'h018
`define TPMC_OFF_FSET 12'h01C
`define TPMC_OFF_COND 12'h020
`define TPMC_OFF_POL 12'h024
// command word fields
`define TPMC_CMD_OP_LSB 0
`define TPMC_CMD_OP_MSB 3
`define TPMC_CMD_CH_LSB 4
`define TPMC_CMD_CH_MSB 9
`define TPMC_CMD_LIST_BIT 10
`define TPMC_CMD_VAL_BIT 11
`define TPMC_CMD_LAST_LSB 16
`define TPMC_CMD_LAST_MSB 21
// status bits
`define TPMC_ST_DONE 0
`define TPMC_ST_ERR 1
`define TPMC_ST_CLR 2
// query reply string codes, ascii
`define TPMC_STR_INIT 32'h494E4954
`define TPMC_STR_TRIG 32'h54524947
// polarity reset value, status width
`define TPMC_POL_DEFAULT 1'b0
`define TPMC_STAT_W 3
`endif

//--- rtl/tpmc_pkg.sv
package tpmc_pkg;
	typedef enum logic [3:0]
	{
		TPMC_OP_NOP = 4'h0,
		TPMC_OP_SET_CLRMODE = 4'h1,
		TPMC_OP_Q_CLRMODE = 4'h2,
		TPMC_OP_SET_FM = 4'h3,
		TPMC_OP_Q_FM = 4'h4,
		TPMC_OP_SET_PWM = 4'h5,
		TPMC_OP_Q_PWM = 4'h6,
		TPMC_OP_SQUARE = 4'h7,
		TPMC_OP_PULSE = 4'h8,
		TPMC_OP_COND = 4'h9,
		TPMC_OP_RST = 4'hA
	} tpmc_op_t;
	typedef enum logic [1:0]
	{
		TPMC_SHAPE_PULSE = 2'b01,
		TPMC_SHAPE_SQUARE = 2'b10
	} tpmc_shape_t;
	typedef enum logic [2:0]
	{
		TPMC_PM_SINGLE = 3'b001,
		TPMC_PM_FREQ = 3'b010,
		TPMC_PM_WIDTH = 3'b100
	} tpmc_pmode_t;
endpackage : tpmc_pkg

//--- rtl/tpmc_top.sv
`include "tpmc_defs.svh"
module tpmc_top #(
	parameter int NCH = 64,
	parameter int FW = 32
)
(
	input wire logic CLK,
	input wire logic NRST,
	input wire logic CE,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic INITIATE,
	input wire logic SCAN_TRIG,
	input wire logic ALGO_WR,
	input wire logic [5:0] ALGO_CH,
	input wire logic [FW-1:0] ALGO_VAL,
	output logic [NCH-1:0] COUNT_CLR,
	output logic [NCH-1:0] FM_EN,
	output logic [NCH-1:0] PWM_EN,
	output logic [NCH-1:0] SQUARE_EN,
	output logic [NCH-1:0] COND_FUNC,
	output logic [NCH-1:0] POLARITY,
	output logic IRQ
);
	logic [NCH-1:0] clrmode_q, clrmode_d; // 1 = trigger mode
	logic [NCH-1:0] fm_q, fm_d, pwm_q, pwm_d, sq_q, sq_d, cond_q, cond_d, pol_q, pol_d;
	logic [NCH-1:0] plugon_q, plugon_d, cclr_q, cclr_d, sqen_q, sqen_d;
	logic [FW-1:0] fset_q [NCH];
	logic [FW-1:0] fset_d [NCH];
	logic [31:0] resp_q, resp_d, prdata_q, prdata_d, fsel_q, fsel_d;
	logic [`TPMC_STAT_W-1:0] stat_q, stat_d, mask_q, mask_d, ev;
	logic pready_q, pready_d, pslverr_q, pslverr_d, irq_q, irq_d;
	tpmc_pkg::tpmc_op_t op;
	logic [5:0] ch, last;
	logic islist, val, bad, wr_acc, rd_acc, cmd_go;

	// writes land at the edge that completes the transfer, reads are loaded one edge earlier
	assign wr_acc = PSEL & PENABLE & PWRITE & pready_q;
	assign rd_acc = PSEL & PENABLE & ~PWRITE & ~pready_q;
	assign cmd_go = wr_acc & (PADDR == `TPMC_OFF_CMD);
	assign op = tpmc_pkg::tpmc_op_t'(PWDATA[`TPMC_CMD_OP_MSB:`TPMC_CMD_OP_LSB]);
	assign ch = PWDATA[`TPMC_CMD_CH_MSB:`TPMC_CMD_CH_LSB];
	assign last = PWDATA[`TPMC_CMD_LAST_MSB:`TPMC_CMD_LAST_LSB];
	assign islist = PWDATA[`TPMC_CMD_LIST_BIT];
	assign val = PWDATA[`TPMC_CMD_VAL_BIT];

	// per-channel mode state, command execution
	always_comb
	begin
		clrmode_d = clrmode_q;
		fm_d = fm_q;
		pwm_d = pwm_q;
		sq_d = sq_q;
		cond_d = cond_q;
		pol_d = pol_q;
		plugon_d = plugon_q;
		resp_d = resp_q;
		fsel_d = fsel_q;
		ev = '0;
		ev[`TPMC_ST_CLR] = |cclr_d;
		bad = 1'b0;
		if (cmd_go)
		begin
			ev[`TPMC_ST_DONE] = 1'b1;
			for (int i = 0; i < NCH; i++)
			begin
				if (i[5:0] >= ch && i[5:0] <= (islist ? last : ch) && !plugon_q[i])
					bad = 1'b1;
			end
			if ((op == tpmc_pkg::TPMC_OP_Q_CLRMODE || op == tpmc_pkg::TPMC_OP_Q_FM
				|| op == tpmc_pkg::TPMC_OP_Q_PWM) && islist)
				bad = 1'b1;
			if (op == tpmc_pkg::TPMC_OP_RST)
				bad = 1'b0;
			ev[`TPMC_ST_ERR] = bad;
			if (op == tpmc_pkg::TPMC_OP_RST)
			begin
				fm_d = '0;
				pwm_d = '0;
				cond_d = '1;
				pol_d = {NCH{`TPMC_POL_DEFAULT}};
				clrmode_d = '0;
			end
			else if (!bad)
			begin
				for (int i = 0; i < NCH; i++)
				begin
					if (i[5:0] >= ch && i[5:0] <= (islist ? last : ch))
					begin
						unique case (op)
							tpmc_pkg::TPMC_OP_SET_CLRMODE: clrmode_d[i] = val;
							tpmc_pkg::TPMC_OP_SET_FM:
							begin
								fm_d[i] = val;
								if (val)
									pwm_d[i] = 1'b0;
							end
							tpmc_pkg::TPMC_OP_SET_PWM:
							begin
								pwm_d[i] = val;
								if (val)
									fm_d[i] = 1'b0;
							end
							tpmc_pkg::TPMC_OP_SQUARE:
							begin
								sq_d[i] = 1'b1;
								cond_d[i] = 1'b0;
							end
							tpmc_pkg::TPMC_OP_PULSE:
							begin
								sq_d[i] = 1'b0;
								cond_d[i] = 1'b0;
							end
							tpmc_pkg::TPMC_OP_COND: cond_d[i] = 1'b1;
							default: ;
						endcase
					end
				end
				unique case (op)
					tpmc_pkg::TPMC_OP_Q_CLRMODE:
						resp_d = clrmode_q[ch] ? `TPMC_STR_TRIG : `TPMC_STR_INIT;
					tpmc_pkg::TPMC_OP_Q_FM: resp_d = {31'h0, fm_q[ch]};
					tpmc_pkg::TPMC_OP_Q_PWM: resp_d = {31'h0, pwm_q[ch]};
					default: ;
				endcase
			end
		end
		// only the channels that fit in one data word are reachable here
		if (wr_acc && PADDR == `TPMC_OFF_PLUGON)
			for (int i = 0; i < NCH; i++)
				plugon_d[i] = (i < $bits(PWDATA)) ? PWDATA[i[4:0]] : 1'b0;
		if (wr_acc && PADDR == `TPMC_OFF_POL)
			for (int i = 0; i < NCH; i++)
				pol_d[i] = (i < $bits(PWDATA)) ? PWDATA[i[4:0]] : `TPMC_POL_DEFAULT;
		if (wr_acc && PADDR == `TPMC_OFF_FMODE)
			fsel_d = PWDATA;
		sqen_d = sq_d & fm_d;
	end

	// count clear strobes per channel
	always_comb
	begin
		for (int i = 0; i < NCH; i++)
			cclr_d[i] = clrmode_q[i] ? SCAN_TRIG : INITIATE;
	end

	// frequency settings from algorithm assignments
	always_comb
	begin
		for (int i = 0; i < NCH; i++)
			fset_d[i] = (ALGO_WR && ALGO_CH == i[5:0] && fm_q[i]) ? ALGO_VAL : fset_q[i];
	end

	// apb answer, status and interrupt
	always_comb
	begin
		pready_d = PSEL & PENABLE & ~pready_q;
		pslverr_d = 1'b0;
		prdata_d = prdata_q;
		mask_d = mask_q;
		stat_d = stat_q;
		if (wr_acc && PADDR == `TPMC_OFF_STAT)
			stat_d = stat_q & ~PWDATA[`TPMC_STAT_W-1:0];
		if (wr_acc && PADDR == `TPMC_OFF_MASK)
			mask_d = PWDATA[`TPMC_STAT_W-1:0];
		stat_d = stat_d | ev; // set wins over clear
		if (rd_acc)
		begin
			unique case (PADDR)
				`TPMC_OFF_CMD: prdata_d = '0;
				`TPMC_OFF_RESP: prdata_d = resp_q;
				`TPMC_OFF_STAT: prdata_d = {29'h0, stat_q};
				`TPMC_OFF_MASK: prdata_d = {29'h0, mask_q};
				`TPMC_OFF_FMODE: prdata_d = fsel_q;
				`TPMC_OFF_CLRMODE: prdata_d = 32'(clrmode_q);
				`TPMC_OFF_PLUGON: prdata_d = 32'(plugon_q);
				`TPMC_OFF_FSET: prdata_d = 32'(fset_q[fsel_q[5:0]]);
				`TPMC_OFF_COND: prdata_d = 32'(cond_q);
				`TPMC_OFF_POL: prdata_d = 32'(pol_q);
				default:
				begin
					prdata_d = '0;
					pslverr_d = 1'b1;
				end
			endcase
		end
		irq_d = |(stat_d & mask_d); // tracks the status flops with no lag
	end

	always_ff @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			clrmode_q <= '0;
			fm_q <= '0;
			pwm_q <= '0;
			sq_q <= '0;
			sqen_q <= '0;
			cond_q <= '1;
			pol_q <= {NCH{`TPMC_POL_DEFAULT}};
			plugon_q <= '0;
			cclr_q <= '0;
			resp_q <= '0;
			fsel_q <= '0;
			prdata_q <= '0;
			stat_q <= '0;
			mask_q <= '0;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			irq_q <= 1'b0;
			for (int i = 0; i < NCH; i++)
				fset_q[i] <= '0;
		end
		else if (CE)
		begin
			clrmode_q <= clrmode_d;
			fm_q <= fm_d;
			pwm_q <= pwm_d;
			sq_q <= sq_d;
			sqen_q <= sqen_d;
			cond_q <= cond_d;
			pol_q <= pol_d;
			plugon_q <= plugon_d;
			cclr_q <= cclr_d;
			resp_q <= resp_d;
			fsel_q <= fsel_d;
			prdata_q <= prdata_d;
			stat_q <= stat_d;
			mask_q <= mask_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
			irq_q <= irq_d;
			fset_q <= fset_d;
		end
	end

	assign PRDATA = prdata_q;
	assign PREADY = pready_q;
	assign PSLVERR = pslverr_q;
	assign COUNT_CLR = cclr_q;
	assign FM_EN = fm_q;
	assign PWM_EN = pwm_q;
	assign SQUARE_EN = sqen_q;
	assign COND_FUNC = cond_q;
	assign POLARITY = pol_q;
	assign IRQ = irq_q;

	// checks
	excl_en_a: assert property (@(posedge CLK) disable iff (!NRST) (fm_q & pwm_q) == '0)
		else $error("both modulation enables on");
	init_clr_a: assert property (@(posedge CLK) disable iff (!NRST)
		CE && INITIATE && !SCAN_TRIG && !clrmode_q[0] |=> COUNT_CLR[0])
		else $error("initiate did not clear");
	trig_noclr_a: assert property (@(posedge CLK) disable iff (!NRST)
		CE && !INITIATE && SCAN_TRIG && !clrmode_q[0] |=> !COUNT_CLR[0])
		else $error("trigger cleared initiate channel");
	trig_clr_a: assert property (@(posedge CLK) disable iff (!NRST)
		CE && SCAN_TRIG && clrmode_q[0] |=> COUNT_CLR[0])
		else $error("trigger did not clear");
	bad_err_a: assert property (@(posedge CLK) disable iff (!NRST)
		CE && cmd_go && bad |=> stat_q[`TPMC_ST_ERR])
		else $error("error not flagged");
	list_q_a: assert property (@(posedge CLK) disable iff (!NRST)
		CE && cmd_go && islist && op == tpmc_pkg::TPMC_OP_Q_FM |=> $stable(resp_q))
		else $error("list query answered");
	fm_set_a: assert property (@(posedge CLK) disable iff (!NRST)
		CE && cmd_go && !bad && !islist && op == tpmc_pkg::TPMC_OP_SET_FM && val |=> fm_q[$past(ch)]
		&& !pwm_q[$past(ch)])
		else $error("fm enable not taken");
	rst_cmd_a: assert property (@(posedge CLK) disable iff (!NRST)
		CE && cmd_go && op == tpmc_pkg::TPMC_OP_RST |=> fm_q == '0 && pwm_q == '0 && cond_q == '1)
		else $error("reset command incomplete");
	fset_a: assert property (@(posedge CLK) disable iff (!NRST)
		CE && ALGO_WR && ALGO_CH == 6'h00 && fm_q[0] |=> fset_q[0] == $past(ALGO_VAL))
		else $error("frequency not taken");
	sq_fm_a: assert property (@(posedge CLK) disable iff (!NRST) (SQUARE_EN & ~FM_EN) == '0)
		else $error("square without frequency mode");
	irq_lvl_a: assert property (@(posedge CLK) disable iff (!NRST) IRQ == |(stat_q & mask_q))
		else $error("interrupt level wrong");
	ce_hold_a: assert property (@(posedge CLK) disable iff (!NRST)
		!CE |=> $stable(fm_q) && $stable(clrmode_q) && $stable(stat_q))
		else $error("state moved while disabled");
	cov_trig_c: cover property (@(posedge CLK) CE && SCAN_TRIG && clrmode_q != '0);
	cov_sq_c: cover property (@(posedge CLK) SQUARE_EN != '0);
	cov_err_c: cover property (@(posedge CLK) CE && cmd_go && bad);
	cov_irq_c: cover property (@(posedge CLK) IRQ);
endmodule : tpmc_top

//--- verif/tb.sv
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, nrst, psel, penable, pwrite, pslverr, pready, irq, e, ce;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, v;
	logic [63:0] cclr, fm, pwm, sq, cond, pol, fm_m, pwm_m;
	logic ini, scn, awr;
	logic [5:0] ach;
	logic [31:0] aval;
	int n_mismatch, check_count, c, k;
	tpmc_host_model i_host (.clk(clk), .initiate(ini), .scan_trig(scn), .algo_wr(awr), .algo_ch(ach),
		.algo_val(aval));
	tpmc_top i_dut (.CLK(clk), .NRST(nrst), .CE(ce), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.INITIATE(ini), .SCAN_TRIG(scn), .ALGO_WR(awr), .ALGO_CH(ach), .ALGO_VAL(aval), .COUNT_CLR(cclr),
		.FM_EN(fm), .PWM_EN(pwm), .SQUARE_EN(sq), .COND_FUNC(cond), .POLARITY(pol), .IRQ(irq));
	// clock
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic chk(input string nm, input logic [63:0] ex, input logic [63:0] got);
		check_count++;
		if (got !== ex)
		begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, ex, got);
		end
	endtask : chk
	task automatic end_of_test;
		$display("mismatches %0d checks %0d", n_mismatch, check_count);
		if (n_mismatch == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_of_test
	// one apb transfer: request held until pready is seen at a rising edge, then settles half a cycle
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		rd = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(negedge clk);
		if (n >= 50)
			chk("pready", 1, 0);
	endtask : apb
	task automatic cmd(input logic [3:0] op, input int ch, input logic val, input logic lst);
		apb(1'b1, 12'h000, 32'(op) | (32'(ch) << 4) | (32'(lst) << 10) | (32'(val) << 11));
	endtask : cmd
	// watchdog
	initial
	begin
		#2000000;
		n_mismatch++;
		end_of_test();
	end
	// main sequence
	initial
	begin
		{nrst, psel, penable, pwrite, paddr, pwdata, fm_m, pwm_m} = '0;
		ce = 1'b1;
		v = $urandom(61348);
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		chk("fm rst", 0, fm);
		chk("pwm rst", 0, pwm);
		chk("cond rst", '1, cond);
		apb(1'b1, 12'h018, ($urandom & ~32'h00000020) | 32'h00000006);
		cmd(4'h2, 1, 0, 0);
		apb(1'b0, 12'h004, 0);
		chk("clr q init", 32'h494E4954, rd);
		cmd(4'h1, 1, 1, 0);
		cmd(4'h2, 1, 0, 0);
		apb(1'b0, 12'h004, 0);
		chk("clr q trig", 32'h54524947, rd);
		i_host.fire(1, 0, 0);
		@(negedge clk);
		chk("scan clr", 1, cclr[2:1]);
		i_host.fire(0, 0, 0);
		@(negedge clk);
		chk("init clr", 1, cclr[2]);
		for (k = 0; k < 8; k++)
		begin
			c = 1 + $urandom % 2;
			v = $urandom % 2;
			if (k > 5)
				v = 0;
			if (k % 2 == 1)
			begin
				cmd(4'h5, c, v[0], 0);
				pwm_m[c] = v[0];
				if (v[0])
					fm_m[c] = 1'b0;
			end
			else
			begin
				cmd(4'h3, c, v[0], 0);
				fm_m[c] = v[0];
				if (v[0])
					pwm_m[c] = 1'b0;
			end
			chk("fm", fm_m, fm);
			chk("pwm", pwm_m, pwm);
			cmd(4'h4, c, 0, 0);
			apb(1'b0, 12'h004, 0);
			chk("fm q", 32'(fm_m[c]), rd);
		end
		cmd(4'h3, 1, 1, 0);
		cmd(4'h7, 1, 0, 0);
		chk("square", 1, sq[1]);
		v = $urandom;
		i_host.fire(2, 1, v);
		apb(1'b1, 12'h010, 1);
		apb(1'b0, 12'h01C, 0);
		chk("freq", v, rd);
		apb(1'b1, 12'h00C, 2);
		cmd(4'h2, 5, 0, 0);
		apb(1'b0, 12'h008, 0);
		chk("err plug", 1, rd[1]);
		chk("irq on", 1, irq);
		apb(1'b1, 12'h008, 7);
		chk("irq off", 0, irq);
		cmd(4'h4, 1, 0, 1);
		apb(1'b0, 12'h008, 0);
		chk("err list", 1, rd[1]);
		apb(1'b0, 12'h100, 0);
		chk("unmapped", 33'h100000000, {e, rd});
		@(posedge clk);
		ce <= 1'b0;
		i_host.fire(1, 0, 0);
		@(negedge clk);
		chk("ce hold", 0, cclr[1]);
		@(posedge clk);
		ce <= 1'b1;
		apb(1'b1, 12'h024, 32'h0000000F);
		cmd(4'hA, 0, 0, 0);
		chk("fm off", 0, fm | pwm);
		chk("cond", '1, cond);
		chk("pol", 0, pol);
		end_of_test();
	end
endmodule : tb

//--- verif/tpmc_host_model.sv
module tpmc_host_model
(
	input wire logic clk,
	output logic initiate,
	output logic scan_trig,
	output logic algo_wr,
	output logic [5:0] algo_ch,
	output logic [31:0] algo_val
);
	timeunit 1ns;
	timeprecision 1ns;
	// quiet strobes at start
	initial
	begin
		initiate = 1'b0;
		scan_trig = 1'b0;
		algo_wr = 1'b0;
		algo_ch = 6'h00;
		algo_val = 32'h00000000;
	end
	// one-cycle event: 0 initiate, 1 scan trigger, 2 algorithm assignment
	task automatic fire(input int kind, input logic [5:0] ch, input logic [31:0] v);
		@(posedge clk);
		initiate <= (kind == 0);
		scan_trig <= (kind == 1);
		algo_wr <= (kind == 2);
		algo_ch <= ch;
		algo_val <= v;
		@(posedge clk);
		initiate <= 1'b0;
		scan_trig <= 1'b0;
		algo_wr <= 1'b0;
		algo_ch <= ~ch; // released bus shows no stale value
		algo_val <= ~v;
	endtask : fire
endmodule : tpmc_host_model
